/* File: hdl/smbsl_map.svh */
// constants of the smbus slave: strap addresses, alert response address, timing
// assumes a 250 MHz system clock and an included-once policy via the guard
`ifndef SMBSL_MAP_SVH
`define SMBSL_MAP_SVH

// ==========================================================
// device addresses per strap pair (high strap, low strap)
`define SMBSL_ADDR_LL 7'h18
`define SMBSL_ADDR_LO 7'h19
`define SMBSL_ADDR_LH 7'h1A
`define SMBSL_ADDR_OL 7'h29
`define SMBSL_ADDR_OO 7'h2A
`define SMBSL_ADDR_OH 7'h2B
`define SMBSL_ADDR_HL 7'h4C
`define SMBSL_ADDR_HO 7'h4D
`define SMBSL_ADDR_HH 7'h4E

// ==========================================================
// protocol constants
`define SMBSL_ARA        7'h0C
`define SMBSL_CRC_POLY   8'h07
`define SMBSL_CRC_INIT   8'h00
`define SMBSL_PTR_RESET  8'h00
`define SMBSL_BYTE_BITS  4'h8
`define SMBSL_STRAP_WAIT 2'h3

// ==========================================================
// timing
`define SMBSL_TIMEOUT_MS 25
`define SMBSL_CLK_KHZ    250000
`define SMBSL_TIMEOUT_CYC (`SMBSL_TIMEOUT_MS * `SMBSL_CLK_KHZ)

`endif

/* File: hdl/smbsl_pkg.sv */
// types of the smbus slave: protocol states and strap levels
// assumes nothing beyond a systemverilog compiler
package smbsl_pkg;

  // ==========================================================
  // protocol states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_ACK,
    ST_TX,
    ST_TXACK,
    ST_TXGAP,
    ST_WAIT
  } smbsl_state_e;

  // ==========================================================
  // three-state strap level
  typedef enum logic [1:0] {
    STRAP_LOW,
    STRAP_OPEN,
    STRAP_HIGH
  } smbsl_strap_e;

endpackage : smbsl_pkg

/* File: hdl/smbsl_top.sv */
// smbus slave with address pointer, register port, packet check and alert
// assumes async pins (scl, sda, straps), combinational reg_rdata_in from the pointer
`include "smbsl_map.svh"

// Behaviour
// [RQ1] strap levels are captured once after reset and never again
// [RQ2] nine strap combinations select fixed addresses 0x18 to 0x4E
// [RQ3] sda falling while scl high is a start; a new frame begins
// [RQ4] eight bits follow: seven address bits msb first, then direction
// [RQ5] matching address gets ack low on ninth clock, else idle until start
// [RQ6] direction 0 means master writes, 1 means master reads
// [RQ7] each byte is eight bits plus an acknowledge bit
// [RQ8] sda changes only with scl low; sda rising with scl high is stop
// [RQ9] master ends a write with a stop in the tenth clock
// [RQ10] master ends a read with no-ack then a stop
// [RQ11] no mixed directions; writes carry one or two bytes, reads one
// [RQ12] first data byte of every write loads the address pointer
// [RQ13] second write byte goes to the register the pointer selects
// [RQ14] a pointer-only write followed by a read returns the chosen register
// [RQ15] reads use the retained pointer without a fresh pointer write
// [RQ16] separate read and write pointer values are decoded by the register side
// [RQ17] with alert enabled, a limit fault or open sensor pulls alert low
// [RQ18] alert only pulls low or releases, open drain
// [RQ19] master queries the alert response address; never a device address
// [RQ20] with alert active, ack the response address and return own address with lsb 1
// [RQ21] on the response address, lose arbitration when a driven one reads low
// [RQ22] after answering, release alert only if the cause has gone
// [RQ23] optional scl and sda timeouts abort after 25 ms, off by default
// [RQ24] an extra byte carries a crc-8 with polynomial 0x07
// [RQ25] pointer stays across stops and foreign frames, changed only by own writes
module smbsl_top
  import smbsl_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = `SMBSL_TIMEOUT_CYC
) (
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  input  wire logic       scl_in,
  input  wire logic       serial_data_pin_in,
  output logic            serial_data_pin_out,
  output logic            serial_data_pin_oe_out,
  input  wire logic [1:0] addr_strap_low_in,
  input  wire logic [1:0] addr_strap_high_in,
  input  wire logic       alert_enable_in,
  input  wire logic       limit_fault_in,
  input  wire logic       sensor_open_in,
  output logic            alert_pin_out,
  output logic            alert_pin_oe_out,
  input  wire logic       scl_timeout_en_in,
  input  wire logic       sda_timeout_en_in,
  output logic [7:0]      reg_ptr_out,
  output logic [7:0]      reg_wdata_out,
  output logic            reg_wr_out,
  output logic            reg_rd_out,
  input  wire logic [7:0] reg_rdata_in
);

  localparam int TW = $clog2(TIMEOUT_CYCLES + 1);

  // ==========================================================
  // pin synchronisers
  logic [5:0] sync1_r;
  logic [5:0] sync2_r;
  logic       scl_d_r;
  logic       sda_d_r;
  logic       scl_s;
  logic       sda_s;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sync1_r <= 6'h3F;
      sync2_r <= 6'h3F;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      sync1_r <= {addr_strap_high_in, addr_strap_low_in, serial_data_pin_in, scl_in};
      sync2_r <= sync1_r;
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  assign scl_s = sync2_r[0];
  assign sda_s = sync2_r[1];

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  assign scl_rise  = scl_s & ~scl_d_r;
  assign scl_fall  = ~scl_s & scl_d_r;
  assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s; // see [RQ3]
  assign stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s; // see [RQ8]

  // ==========================================================
  // strap capture and address decode
  function automatic smbsl_strap_e smbsl_class(input logic [1:0] p);
    smbsl_class = p[1] ? (p[0] ? STRAP_HIGH : STRAP_LOW) : STRAP_OPEN;
  endfunction : smbsl_class

  function automatic logic [6:0] smbsl_decode(input smbsl_strap_e hi, input smbsl_strap_e lo);
    logic [6:0] a;
    a = `SMBSL_ADDR_OO;
    unique case (hi)
      STRAP_LOW:  a = (lo == STRAP_LOW) ? `SMBSL_ADDR_LL :
                      (lo == STRAP_OPEN) ? `SMBSL_ADDR_LO : `SMBSL_ADDR_LH;
      STRAP_OPEN: a = (lo == STRAP_LOW) ? `SMBSL_ADDR_OL :
                      (lo == STRAP_OPEN) ? `SMBSL_ADDR_OO : `SMBSL_ADDR_OH;
      STRAP_HIGH: a = (lo == STRAP_LOW) ? `SMBSL_ADDR_HL :
                      (lo == STRAP_OPEN) ? `SMBSL_ADDR_HO : `SMBSL_ADDR_HH;
      default:    a = `SMBSL_ADDR_OO;
    endcase
    smbsl_decode = a;
  endfunction : smbsl_decode

  logic [1:0] strap_cnt_r;
  logic [1:0] strap_cnt_nxt;
  logic       strap_done_r;
  logic       strap_done_nxt;
  logic [6:0] dev_addr_r;
  logic [6:0] dev_addr_nxt;

  always_comb begin
    strap_cnt_nxt  = strap_cnt_r;
    strap_done_nxt = strap_done_r;
    dev_addr_nxt   = dev_addr_r;
    if (!strap_done_r) begin
      if (strap_cnt_r == `SMBSL_STRAP_WAIT) begin
        strap_done_nxt = 1'b1; // see [RQ1]
        dev_addr_nxt   = smbsl_decode(smbsl_class(sync2_r[5:4]),
                                      smbsl_class(sync2_r[3:2])); // see [RQ2]
      end else begin
        strap_cnt_nxt = strap_cnt_r + 2'h1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      strap_cnt_r  <= 2'h0;
      strap_done_r <= 1'b0;
      dev_addr_r   <= `SMBSL_ADDR_OO;
    end else begin
      strap_cnt_r  <= strap_cnt_nxt;
      strap_done_r <= strap_done_nxt;
      dev_addr_r   <= dev_addr_nxt;
    end
  end

  // ==========================================================
  // protocol engine
  smbsl_state_e state_r, state_nxt;
  logic [3:0]   bit_cnt_r, bit_cnt_nxt;
  logic [7:0]   shift_r, shift_nxt;
  logic [1:0]   byte_idx_r, byte_idx_nxt;
  logic         rw_r, rw_nxt;
  logic         ara_r, ara_nxt;
  logic         sda_oe_r, sda_oe_nxt;
  logic [7:0]   crc_r, crc_nxt;
  logic [7:0]   ptr_r, ptr_nxt;
  logic [7:0]   wdata_r, wdata_nxt;
  logic         wr_r, wr_nxt;
  logic         rd_r, rd_nxt;
  logic [TW-1:0] tmo_r, tmo_nxt;
  logic         ara_done;
  logic         alert_r, alert_nxt;
  logic         tmo_hit;
  logic         lost;

  assign tmo_hit = (tmo_r == TW'(TIMEOUT_CYCLES - 1));
  assign lost    = (state_r == ST_TX) && scl_rise && !sda_oe_r && !sda_s;

  function automatic logic [7:0] smbsl_crc(input logic [7:0] c, input logic b);
    smbsl_crc = {c[6:0], 1'b0} ^ ((c[7] ^ b) ? `SMBSL_CRC_POLY : 8'h00); // see [RQ24]
  endfunction : smbsl_crc

  always_comb begin
    state_nxt    = state_r;
    bit_cnt_nxt  = bit_cnt_r;
    shift_nxt    = shift_r;
    byte_idx_nxt = byte_idx_r;
    rw_nxt       = rw_r;
    ara_nxt      = ara_r;
    sda_oe_nxt   = sda_oe_r;
    crc_nxt      = crc_r;
    ptr_nxt      = ptr_r;
    wdata_nxt    = wdata_r;
    wr_nxt       = 1'b0;
    rd_nxt       = 1'b0;
    ara_done     = 1'b0;
    if ((state_r != ST_IDLE) &&
        ((scl_timeout_en_in && !scl_s) || (sda_timeout_en_in && !sda_s))) begin
      tmo_nxt = tmo_r + TW'(1);
    end else begin
      tmo_nxt = '0;
    end
    if (start_det) begin
      state_nxt    = ST_RX; // see [RQ3]
      bit_cnt_nxt  = 4'h0;
      byte_idx_nxt = 2'h0;
      crc_nxt      = `SMBSL_CRC_INIT;
      sda_oe_nxt   = 1'b0;
      tmo_nxt      = '0;
    end else if (stop_det || tmo_hit) begin
      state_nxt  = ST_IDLE; // see [RQ8] see [RQ23]
      sda_oe_nxt = 1'b0;
      tmo_nxt    = '0;
    end else begin
      unique case (state_r)
        ST_IDLE, ST_WAIT: begin
        end
        ST_RX: begin
          if (scl_rise) begin
            shift_nxt   = {shift_r[6:0], sda_s}; // see [RQ4]
            bit_cnt_nxt = bit_cnt_r + 4'h1;
            crc_nxt     = smbsl_crc(crc_r, sda_s);
          end else if (scl_fall && bit_cnt_r == `SMBSL_BYTE_BITS) begin
            state_nxt  = ST_ACK; // see [RQ7]
            sda_oe_nxt = 1'b1;
            unique case (byte_idx_r)
              2'h0: begin
                rw_nxt  = shift_r[0]; // see [RQ6]
                ara_nxt = 1'b0;
                if (shift_r[7:1] == dev_addr_r) begin
                  rd_nxt = shift_r[0];
                end else if (shift_r[7:1] == `SMBSL_ARA && shift_r[0] && alert_r) begin
                  ara_nxt = 1'b1; // see [RQ20]
                end else begin
                  state_nxt  = ST_WAIT; // see [RQ5]
                  sda_oe_nxt = 1'b0;
                end
              end
              2'h1: ptr_nxt = shift_r; // see [RQ12] see [RQ25]
              2'h2: begin
                wdata_nxt = shift_r; // see [RQ13]
                wr_nxt    = 1'b1;
              end
              default: begin
                if (crc_r != 8'h00) begin
                  state_nxt  = ST_WAIT; // see [RQ24]
                  sda_oe_nxt = 1'b0;
                end
              end
            endcase
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            bit_cnt_nxt  = 4'h0;
            byte_idx_nxt = byte_idx_r + 2'h1;
            if (byte_idx_r == 2'h3) begin
              state_nxt  = ST_WAIT; // see [RQ11]
              sda_oe_nxt = 1'b0;
            end else if (rw_r) begin
              state_nxt  = ST_TX; // see [RQ15] see [RQ14] see [RQ16]
              shift_nxt  = ara_r ? {dev_addr_r, 1'b1} : reg_rdata_in; // see [RQ20]
              sda_oe_nxt = ara_r ? ~dev_addr_r[6] : ~reg_rdata_in[7];
            end else begin
              state_nxt  = ST_RX;
              sda_oe_nxt = 1'b0;
            end
          end
        end
        ST_TX: begin
          if (lost) begin
            state_nxt  = ST_WAIT; // see [RQ21]
            sda_oe_nxt = 1'b0;
          end else if (scl_rise) begin
            bit_cnt_nxt = bit_cnt_r + 4'h1;
            crc_nxt     = smbsl_crc(crc_r, sda_s);
          end else if (scl_fall) begin
            if (bit_cnt_r == `SMBSL_BYTE_BITS) begin
              state_nxt  = ST_TXACK;
              sda_oe_nxt = 1'b0;
            end else begin
              shift_nxt  = {shift_r[6:0], 1'b0};
              sda_oe_nxt = ~shift_r[6];
            end
          end
        end
        ST_TXACK: begin
          if (scl_rise) begin
            ara_done  = ara_r && (byte_idx_r == 2'h1); // see [RQ22]
            state_nxt = (!sda_s && byte_idx_r == 2'h1) ? ST_TXGAP : ST_WAIT; // see [RQ10]
          end
        end
        ST_TXGAP: begin
          if (scl_fall) begin
            state_nxt    = ST_TX; // see [RQ24]
            bit_cnt_nxt  = 4'h0;
            byte_idx_nxt = 2'h2;
            shift_nxt    = crc_r;
            sda_oe_nxt   = ~crc_r[7];
          end
        end
      endcase
    end
    alert_nxt = alert_r;
    if (alert_enable_in && (limit_fault_in || sensor_open_in)) begin
      alert_nxt = 1'b1; // see [RQ17]
    end else if (ara_done || !alert_enable_in) begin
      alert_nxt = 1'b0; // see [RQ22]
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_r    <= ST_IDLE;
      bit_cnt_r  <= 4'h0;
      shift_r    <= 8'h00;
      byte_idx_r <= 2'h0;
      rw_r       <= 1'b0;
      ara_r      <= 1'b0;
      sda_oe_r   <= 1'b0;
      crc_r      <= `SMBSL_CRC_INIT;
      ptr_r      <= `SMBSL_PTR_RESET;
      wdata_r    <= 8'h00;
      wr_r       <= 1'b0;
      rd_r       <= 1'b0;
      tmo_r      <= '0;
      alert_r    <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      bit_cnt_r  <= bit_cnt_nxt;
      shift_r    <= shift_nxt;
      byte_idx_r <= byte_idx_nxt;
      rw_r       <= rw_nxt;
      ara_r      <= ara_nxt;
      sda_oe_r   <= sda_oe_nxt;
      crc_r      <= crc_nxt;
      ptr_r      <= ptr_nxt;
      wdata_r    <= wdata_nxt;
      wr_r       <= wr_nxt;
      rd_r       <= rd_nxt;
      tmo_r      <= tmo_nxt;
      alert_r    <= alert_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign serial_data_pin_out    = 1'b0;
  assign serial_data_pin_oe_out = sda_oe_r;
  assign alert_pin_out          = 1'b0; // see [RQ18]
  assign alert_pin_oe_out       = alert_r;
  assign reg_ptr_out            = ptr_r;
  assign reg_wdata_out          = wdata_r;
  assign reg_wr_out             = wr_r;
  assign reg_rd_out             = rd_r;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  sequence s_start;
    start_det;
  endsequence
  sequence s_stop;
    stop_det && !start_det;
  endsequence
  sequence s_alert_cause;
    alert_enable_in && (limit_fault_in || sensor_open_in);
  endsequence

  property p_strap_hold;
    strap_done_r |=> $stable(dev_addr_r) && strap_done_r;
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap address changed"); // see [RQ1]

  property p_not_ara;
    strap_done_r |-> dev_addr_r != `SMBSL_ARA;
  endproperty
  a_not_ara: assert property (p_not_ara) else $error("device address is response address"); // see [RQ19]

  property p_start;
    s_start |=> state_r == ST_RX && bit_cnt_r == 4'h0 && !sda_oe_r;
  endproperty
  a_start: assert property (p_start) else $error("start not taken"); // see [RQ3]

  property p_stop;
    s_stop |=> state_r == ST_IDLE && !sda_oe_r;
  endproperty
  a_stop: assert property (p_stop) else $error("stop not taken"); // see [RQ8]

  property p_ack_held;
    state_r == ST_ACK && !start_det && !stop_det && !tmo_hit |-> sda_oe_r;
  endproperty
  a_ack_held: assert property (p_ack_held) else $error("ack not driven low"); // see [RQ5]

  property p_ptr_only_first;
    !$stable(ptr_r) |-> $past(state_r) == ST_RX && $past(byte_idx_r) == 2'h1 && !$past(rw_r);
  endproperty
  a_ptr_only_first: assert property (p_ptr_only_first) else $error("pointer changed late"); // see [RQ25]

  property p_wr_pulse;
    reg_wr_out |-> $past(byte_idx_r) == 2'h2 ##1 !reg_wr_out;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe wrong"); // see [RQ13]

  property p_alert_set;
    s_alert_cause |=> alert_pin_oe_out && !alert_pin_out;
  endproperty
  a_alert_set: assert property (p_alert_set) else $error("alert not pulled low"); // see [RQ17]

  property p_arb;
    lost && !start_det && !stop_det && !tmo_hit |=> !sda_oe_r && state_r == ST_WAIT;
  endproperty
  a_arb: assert property (p_arb) else $error("arbitration loss ignored"); // see [RQ21]

  property p_timeout;
    tmo_hit && !start_det |=> state_r == ST_IDLE && tmo_r == '0;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout not taken"); // see [RQ23]

endmodule : smbsl_top

/* File: verification/smbsl_master.sv */
// smbus master model: drives scl, pulls sda low, one bit per 32 ns
// assumes an sda wire with pull-up resolved by the bench, scl idle high
module smbsl_master (
  input  wire logic clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_oe_out
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
  end

  // ==========================================================
  // bit, start, stop
  task automatic bit_io(input logic b, output logic r);
    @(posedge clk_in);
    sda_oe_out <= ~b;
    repeat (3) @(posedge clk_in);
    scl_out <= 1'b1;
    repeat (4) @(posedge clk_in);
    r = sda_in;
    scl_out <= 1'b0;
  endtask : bit_io

  task automatic start();
    @(posedge clk_in);
    sda_oe_out <= 1'b0;
    repeat (3) @(posedge clk_in);
    scl_out <= 1'b1;
    repeat (4) @(posedge clk_in);
    sda_oe_out <= 1'b1;
    repeat (4) @(posedge clk_in);
    scl_out <= 1'b0;
  endtask : start

  task automatic stop();
    @(posedge clk_in);
    sda_oe_out <= 1'b1;
    repeat (3) @(posedge clk_in);
    scl_out <= 1'b1;
    repeat (4) @(posedge clk_in);
    sda_oe_out <= 1'b0;
    repeat (8) @(posedge clk_in);
  endtask : stop

  // ==========================================================
  // bytes, msb first, ack in the ninth bit
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask : wbyte

  task automatic rbyte(input logic ack_it, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(~ack_it, r);
  endtask : rbyte
endmodule : smbsl_master

/* File: verification/tb.sv */
// self-checking bench of the smbus slave with a master model
// assumes a pulled-up sda wire and a combinational register read port
module tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic       clk, resetn, scl, m_oe, sda_do, sda_oe, al_o, al_oe, wr, rd;
  logic       al_en, fault, sopen, sto_en, dto_en;
  logic [1:0] st_lo, st_hi;
  logic [7:0] ptr, wdata, rdata, wr_data;
  wire        sda = ~(m_oe | (sda_oe & ~sda_do));
  int         mismatches, checked, cycles, wr_cnt, rd_cnt;
  logic [6:0] addr_tab [9] = '{7'h18, 7'h19, 7'h1A, 7'h29, 7'h2A, 7'h2B, 7'h4C, 7'h4D, 7'h4E};

  assign rdata = ptr ^ 8'h5A;

  smbsl_top #(.TIMEOUT_CYCLES(200)) smbsl_top_i (
    .clk_in(clk), .resetn_in(resetn), .scl_in(scl), .serial_data_pin_in(sda),
    .serial_data_pin_out(sda_do), .serial_data_pin_oe_out(sda_oe),
    .addr_strap_low_in(st_lo), .addr_strap_high_in(st_hi), .alert_enable_in(al_en),
    .limit_fault_in(fault), .sensor_open_in(sopen), .alert_pin_out(al_o),
    .alert_pin_oe_out(al_oe), .scl_timeout_en_in(sto_en), .sda_timeout_en_in(dto_en),
    .reg_ptr_out(ptr), .reg_wdata_out(wdata), .reg_wr_out(wr), .reg_rd_out(rd),
    .reg_rdata_in(rdata));

  smbsl_master smbsl_master_i (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_oe_out(m_oe));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (wr === 1'b1) begin
      wr_cnt++;
      wr_data = wdata;
    end
    if (rd === 1'b1) rd_cnt++;
    if (cycles == 80000) begin
      mismatches++;
      print_verdict();
    end
  end

  // ==========================================================
  // helpers
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic [1:0] strap(input int k);
    return (k == 0) ? 2'b10 : (k == 1) ? 2'b00 : 2'b11;
  endfunction : strap

  function automatic logic [7:0] crc8(input logic [23:0] m);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 23; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ m[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction : crc8

  task automatic do_reset(input int hi, input int lo);
    @(posedge clk);
    resetn <= 1'b0;
    st_hi <= strap(hi);
    st_lo <= strap(lo);
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    repeat (12) @(posedge clk);
  endtask : do_reset

  task automatic wframe(input logic [6:0] a, input logic [7:0] p, input logic two,
                        input logic [7:0] dat, output logic [2:0] acks);
    acks = 3'h0;
    smbsl_master_i.start();
    smbsl_master_i.wbyte({a, 1'b0}, acks[2]);
    if (acks[2]) smbsl_master_i.wbyte(p, acks[1]);
    if (two && acks[2]) smbsl_master_i.wbyte(dat, acks[0]);
    smbsl_master_i.stop();
  endtask : wframe

  task automatic rframe(input logic [6:0] a, output logic ack, output logic [7:0] d);
    d = 8'h00;
    smbsl_master_i.start();
    smbsl_master_i.wbyte({a, 1'b1}, ack);
    if (ack) smbsl_master_i.rbyte(1'b0, d);
    smbsl_master_i.stop();
  endtask : rframe

  // ==========================================================
  // scenarios
  task automatic t_strap();
    logic [2:0] a;
    for (int k = 0; k < 9; k++) begin
      do_reset(k / 3, k % 3);
      wframe(addr_tab[k], 8'h10 + 8'(k), 1'b0, 8'h00, a);
      chk(8'(a[2:1]), 8'h03);
      chk(ptr, 8'h10 + 8'(k));
    end
    @(posedge clk);
    st_hi <= strap(0);
    st_lo <= strap(0);
    wframe(addr_tab[8], 8'h33, 1'b0, 8'h00, a);
    chk(8'(a[2]), 8'h01);
    wframe(addr_tab[0], 8'h44, 1'b0, 8'h00, a);
    chk(8'(a[2]), 8'h00);
    chk(ptr, 8'h33);
  endtask : t_strap

  task automatic t_rw();
    logic [2:0] a;
    logic       k;
    logic [7:0] d;
    int         n, m;
    n = wr_cnt;
    wframe(addr_tab[8], 8'h22, 1'b1, 8'hA5, a);
    chk(8'(a), 8'h07);
    chk(8'(wr_cnt - n), 8'h01);
    chk(wr_data, 8'hA5);
    chk(ptr, 8'h22);
    n = wr_cnt;
    m = rd_cnt;
    wframe(addr_tab[8], 8'h05, 1'b0, 8'h00, a);
    chk(8'(wr_cnt - n), 8'h00);
    rframe(addr_tab[8], k, d);
    chk(d, 8'h5F);
    wframe(7'h7F, 8'hEE, 1'b0, 8'h00, a);
    rframe(addr_tab[8], k, d);
    chk(d, 8'h5F);
    chk(8'(rd_cnt - m), 8'h02);
  endtask : t_rw

  task automatic t_pec(input logic good);
    logic [7:0] c;
    logic       a0, a1, a2, a3;
    c = crc8({addr_tab[8], 1'b0, 16'h2133});
    smbsl_master_i.start();
    smbsl_master_i.wbyte({addr_tab[8], 1'b0}, a0);
    smbsl_master_i.wbyte(8'h21, a1);
    smbsl_master_i.wbyte(8'h33, a2);
    smbsl_master_i.wbyte(good ? c : ~c, a3);
    smbsl_master_i.stop();
    chk(8'(a3), 8'(good));
  endtask : t_pec

  task automatic t_alert();
    logic       k;
    logic [7:0] d;
    @(posedge clk);
    fault <= 1'b1;
    repeat (4) @(posedge clk);
    chk(8'(al_oe), 8'h01);
    chk(8'(al_o), 8'h00);
    rframe(7'h0C, k, d);
    chk(8'(k), 8'h01);
    chk(d, {addr_tab[8], 1'b1});
    chk(8'(al_oe), 8'h01);
    // a lower-addressed rival drives zeros: the slave must withdraw
    smbsl_master_i.start();
    smbsl_master_i.wbyte({7'h0C, 1'b1}, k);
    chk(8'(k), 8'h01);
    smbsl_master_i.wbyte(8'h00, k);
    chk(8'(sda_oe), 8'h00);
    smbsl_master_i.stop();
    chk(8'(al_oe), 8'h01);
    fault <= 1'b0;
    rframe(7'h0C, k, d);
    chk(8'(al_oe), 8'h00);
    sopen <= 1'b1;
    repeat (4) @(posedge clk);
    chk(8'(al_oe), 8'h01);
    al_en <= 1'b0;
    repeat (4) @(posedge clk);
    chk(8'(al_oe), 8'h00);
    rframe(7'h0C, k, d);
    chk(8'(k), 8'h00);
    sopen <= 1'b0;
    al_en <= 1'b1;
  endtask : t_alert

  task automatic t_timeout(input logic [1:0] en);
    logic [7:0] b;
    logic       r;
    b = {addr_tab[8], 1'b0};
    @(posedge clk);
    sto_en <= en[0];
    dto_en <= en[1];
    smbsl_master_i.start();
    for (int i = 7; i >= 0; i--) smbsl_master_i.bit_io(b[i], r);
    repeat (260) @(posedge clk);
    chk(8'(sda_oe), 8'(en == 2'b00));
    smbsl_master_i.bit_io(1'b1, r);
    smbsl_master_i.stop();
    sto_en <= 1'b0;
    dto_en <= 1'b0;
  endtask : t_timeout

  task automatic print_verdict();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  initial begin
    resetn = 1'b0;
    st_lo = 2'b10;
    st_hi = 2'b10;
    al_en = 1'b1;
    fault = 1'b0;
    sopen = 1'b0;
    sto_en = 1'b0;
    dto_en = 1'b0;
    t_strap();
    t_rw();
    t_pec(1'b1);
    t_pec(1'b0);
    t_alert();
    t_timeout(2'b00);
    t_timeout(2'b01);
    t_timeout(2'b10);
    print_verdict();
  end
endmodule : tb
